// ---- rtl/cbu_branch_unit.sv ----
// Purpose: decode and resolve the compare-and-branch instruction group
// Assumes: one instruction offered per issue_valid cycle; the slot
//          instruction follows the branch; operands are already read
// Notes:   outcome is registered and shows one cycle after the branch
//
// Notes on behaviour
// (RULE1) target is slot address plus scaled offset
// (RULE2) equal branch redirects when sources match
// (RULE3) equal likely nullifies slot when not taken
// (RULE4) nonnegative branch tests the sign bit
// (RULE5) link variant always writes return address
// (RULE6) link with source 31 raises nothing
// (RULE7) link likely links and nullifies when untaken
// (RULE8) likely nonnegative nullifies slot when untaken
// (RULE9) positive branch needs clear sign, nonzero
// (RULE10) positive likely nullifies slot when untaken
// (RULE11) nonpositive branch: sign set or zero
// (RULE12) cop condition sampled one instruction early
// (RULE13) cop branch nullifies or raises unusable
// (RULE14) software spaces condition change from branch
// (RULE15) resolve in branch cycle, apply next cycle
// (RULE16) fixed field layout of the instruction word
`timescale 1ns/10ps
`default_nettype none
module cbu_branch_unit #(
    parameter int unsigned DATA_W = cbu_pkg::DATA_W
) (
    input  wire logic                   clk,
    input  wire logic                   nrst,
    // an instruction is issued this cycle
    input  wire logic                   issue_valid,
    input  wire logic [31:0]            instr,
    // address of the issued instruction
    input  wire logic [DATA_W-1:0]      branch_pc,
    // register file read data for the two source fields
    input  wire logic [DATA_W-1:0]      first_source_value,
    input  wire logic [DATA_W-1:0]      second_source_value,
    // 64-bit operating mode
    input  wire logic                   mode64,
    // coprocessor 0 usable by the current program
    input  wire logic                   cop0_usable,
    // live coprocessor condition from the status register
    input  wire logic                   status_condition_bit,
    // first source index, for the link hazard flag
    output logic [4:0]                  first_source_field,
    output logic [4:0]                  second_source_field,
    // program counter redirect, one cycle wide
    output logic                        redirect_valid,
    output logic [DATA_W-1:0]           redirect_pc,
    // slot instruction must be discarded
    output logic                        nullify_slot,
    // return address write
    output logic                        link_write,
    output logic [4:0]                  link_index,
    output logic [DATA_W-1:0]           link_value,
    // coprocessor unusable exception request
    output logic                        cop_unusable_exc,
    // link branch named r31 as its source (not restartable)
    output logic                        link_self_hazard,
    // a branch outcome is being applied this cycle
    output logic                        resolve_busy
);

    // decoded fields
    localparam int unsigned OFF_W_L = cbu_pkg::OFF_W;
    logic [5:0]          opcode;
    logic [OFF_W_L-1:0]  offset_field;

    // operand tests
    logic                sign_set;
    logic                is_zero;
    logic                src_equal;

    // decode results for the current instruction
    logic                is_branch;
    logic                is_likely;
    logic                is_link;
    logic                is_cop;
    logic                cond_now;

    // address arithmetic
    logic [DATA_W-1:0]   offset_ext;
    logic [DATA_W-1:0]   slot_addr;
    logic [DATA_W-1:0]   target_raw;
    logic [DATA_W-1:0]   link_raw;

    // condition sampled during the previous instruction
    logic                cop_cond_reg;

    // sequencing state
    cbu_pkg::cbu_state_t state_reg;
    cbu_pkg::cbu_state_t state_next;

    // registered outcome
    logic                redirect_reg;
    logic [DATA_W-1:0]   target_reg;
    logic                nullify_reg;
    logic                link_reg;
    logic [DATA_W-1:0]   link_value_reg;
    logic                exc_reg;
    logic                hazard_reg;

    // fold a 64-bit address to the 32-bit view in 32-bit mode
    function automatic logic [DATA_W-1:0] fold_addr(
        input logic [DATA_W-1:0] a,
        input logic              wide
    );
        logic [DATA_W-1:0] r;
        r = wide ? a : {{(DATA_W-cbu_pkg::HALF_W){a[cbu_pkg::SIGN32_BIT]}},
                        a[cbu_pkg::HALF_W-1:0]};
        return r;
    endfunction

    // (RULE16) field extraction
    assign opcode              = instr[cbu_pkg::OPC_HI:cbu_pkg::OPC_LO];
    assign first_source_field  = instr[cbu_pkg::SRC1_HI:cbu_pkg::SRC1_LO];
    assign second_source_field = instr[cbu_pkg::SRC2_HI:cbu_pkg::SRC2_LO];
    assign offset_field        = instr[cbu_pkg::OFF_HI:cbu_pkg::OFF_LO];

    // sign, zero and equality tests on the operands
    cbu_cond_eval #(
        .WIDTH (DATA_W)
    ) u_cond (
        .first_value  (first_source_value),
        .second_value (second_source_value),
        .mode64       (mode64),
        .sign_set     (sign_set),
        .is_zero      (is_zero),
        .equal        (src_equal)
    );

    // (RULE1) offset scaled by four and sign-extended
    assign offset_ext = {{(DATA_W-OFF_W_L-cbu_pkg::OFF_SHIFT){offset_field[OFF_W_L-1]}},
                         offset_field, {cbu_pkg::OFF_SHIFT{1'b0}}};
    // the target is relative to the slot, not to the branch itself
    assign slot_addr  = branch_pc + cbu_pkg::SLOT_OFFSET;
    // (RULE1) target from slot address
    assign target_raw = fold_addr(slot_addr + offset_ext, mode64);
    // return address skips the slot; wraps in 32-bit mode
    assign link_raw   = fold_addr(branch_pc + cbu_pkg::LINK_OFFSET, mode64);

    // instruction decode: which branch, and its condition
    always_comb begin
        is_branch = 1'b0;
        is_likely = 1'b0;
        is_link   = 1'b0;
        is_cop    = 1'b0;
        cond_now  = 1'b0;
        case (opcode)
            // (RULE2) equal compare
            cbu_pkg::OPC_EQ: begin
                is_branch = 1'b1;
                cond_now  = src_equal;
            end
            // (RULE3) equal likely
            cbu_pkg::OPC_EQ_LIKELY: begin
                is_branch = 1'b1;
                is_likely = 1'b1;
                cond_now  = src_equal;
            end
            // (RULE9) strictly positive; second field assumed zero
            cbu_pkg::OPC_POS: begin
                is_branch = 1'b1;
                cond_now  = !sign_set && !is_zero;
            end
            // (RULE10) positive likely
            cbu_pkg::OPC_POS_LIKELY: begin
                is_branch = 1'b1;
                is_likely = 1'b1;
                cond_now  = !sign_set && !is_zero;
            end
            // (RULE11) sign set or zero
            cbu_pkg::OPC_NONPOS: begin
                is_branch = 1'b1;
                cond_now  = sign_set || is_zero;
            end
            // register immediate group, selector in second field
            cbu_pkg::OPC_REGISTER_IMMEDIATE_GROUP: begin
                // (RULE4) all four variants test sign clear
                cond_now = !sign_set;
                case (second_source_field)
                    cbu_pkg::SEL_NONNEG: begin
                        is_branch = 1'b1;
                    end
                    // (RULE8) likely without link
                    cbu_pkg::SEL_NONNEG_L: begin
                        is_branch = 1'b1;
                        is_likely = 1'b1;
                    end
                    // (RULE5) link, plain
                    cbu_pkg::SEL_NONNEG_AL: begin
                        is_branch = 1'b1;
                        is_link   = 1'b1;
                    end
                    // (RULE7) link and likely
                    cbu_pkg::SEL_NONNEG_ALL: begin
                        is_branch = 1'b1;
                        is_link   = 1'b1;
                        is_likely = 1'b1;
                    end
                    // other selectors belong elsewhere
                    default: begin
                        cond_now = 1'b0;
                    end
                endcase
            end
            // coprocessor 0 condition-true-likely branch
            cbu_pkg::OPC_COP0: begin
                if (first_source_field == cbu_pkg::COP_BC &&
                    second_source_field == cbu_pkg::COP_TRUE_L) begin
                    is_branch = 1'b1;
                    is_likely = 1'b1;
                    is_cop    = 1'b1;
                    // (RULE12) uses the early-sampled condition
                    cond_now  = cop_cond_reg;
                end
            end
            // not a branch of this group
            default: begin
                is_branch = 1'b0;
            end
        endcase
    end

    // (RULE12) sample the condition on every issued instruction
    // (RULE14) a change just before the branch is not seen
    always_ff @(posedge clk) begin
        if (!nrst) begin
            cop_cond_reg <= 1'b0;
        end else if (issue_valid) begin
            // the branch itself reads the old value this cycle
            cop_cond_reg <= status_condition_bit;
        end
    end

    // next state: a branch moves to resolve for one cycle
    always_comb begin
        state_next = cbu_pkg::CBU_IDLE;
        case (state_reg)
            cbu_pkg::CBU_IDLE: begin
                if (issue_valid && is_branch) begin
                    state_next = cbu_pkg::CBU_RESOLVE;
                end
            end
            // a branch in the slot is undefined; still resolved in turn
            cbu_pkg::CBU_RESOLVE: begin
                if (issue_valid && is_branch) begin
                    state_next = cbu_pkg::CBU_RESOLVE;
                end
            end
            default: begin
                state_next = cbu_pkg::CBU_IDLE;
            end
        endcase
    end

    // (RULE15) state register
    always_ff @(posedge clk) begin
        if (!nrst) begin
            state_reg <= cbu_pkg::CBU_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // (RULE15) redirect decided now, applied next cycle
    always_ff @(posedge clk) begin
        if (!nrst) begin
            redirect_reg <= 1'b0;
            target_reg   <= '0;
        end else begin
            // (RULE13) an unusable coprocessor blocks the branch
            redirect_reg <= issue_valid && is_branch && cond_now &&
                            !(is_cop && !cop0_usable);
            // target held only when a branch resolves
            if (issue_valid && is_branch) begin
                target_reg <= target_raw;
            end
        end
    end

    // likely forms discard the slot when not taken
    always_ff @(posedge clk) begin
        if (!nrst) begin
            nullify_reg <= 1'b0;
        end else begin
            // (RULE3) (RULE7) (RULE8) (RULE10) nullify untaken likely
            // (RULE13) cop form the same, unless it traps
            nullify_reg <= issue_valid && is_branch && is_likely &&
                           !cond_now && !(is_cop && !cop0_usable);
        end
    end

    // (RULE5) return address written whether taken or not
    always_ff @(posedge clk) begin
        if (!nrst) begin
            link_reg       <= 1'b0;
            link_value_reg <= '0;
        end else begin
            link_reg <= issue_valid && is_link;
            if (issue_valid && is_link) begin
                link_value_reg <= link_raw;
            end
        end
    end

    // exception and hazard flags
    always_ff @(posedge clk) begin
        if (!nrst) begin
            exc_reg    <= 1'b0;
            hazard_reg <= 1'b0;
        end else begin
            // (RULE13) unusable coprocessor traps
            exc_reg    <= issue_valid && is_cop && !cop0_usable;
            // (RULE6) only flagged, never trapped
            hazard_reg <= issue_valid && is_link &&
                          first_source_field == cbu_pkg::LINK_REG;
        end
    end

    // outputs from registers, link_index from the LINK_REG constant
    assign redirect_valid   = redirect_reg;
    assign redirect_pc      = target_reg;
    assign nullify_slot     = nullify_reg;
    assign link_write       = link_reg;
    assign link_index       = cbu_pkg::LINK_REG;
    assign link_value       = link_value_reg;
    assign cop_unusable_exc = exc_reg;
    assign link_self_hazard = hazard_reg;
    assign resolve_busy     = (state_reg == cbu_pkg::CBU_RESOLVE);

endmodule
`default_nettype wire

// ---- rtl/cbu_pkg.sv ----
// Purpose: shared constants for the conditional branch unit
// Assumes: instruction word of 32 bits, general registers of 64 bits
// Notes:   encodings, field positions and address offsets for the RTL live here only; the checker and bench repeat some as literals
package cbu_pkg;

    // operating width of the general registers
    localparam int unsigned DATA_W       = 64;
    // width of an instruction word
    localparam int unsigned INSTR_W      = 32;
    // width of a register index field
    localparam int unsigned REG_IDX_W    = 5;

    // field positions inside the instruction word
    localparam int unsigned OPC_HI       = 31;
    localparam int unsigned OPC_LO       = 26;
    localparam int unsigned SRC1_HI      = 25;
    localparam int unsigned SRC1_LO      = 21;
    localparam int unsigned SRC2_HI      = 20;
    localparam int unsigned SRC2_LO      = 16;
    localparam int unsigned OFF_HI       = 15;
    localparam int unsigned OFF_LO       = 0;
    localparam int unsigned OFF_W        = 16;
    // word offset is scaled to a byte offset by this shift
    localparam int unsigned OFF_SHIFT    = 2;
    // sign bit of a 32-bit operand
    localparam int unsigned SIGN32_BIT   = 31;
    localparam int unsigned HALF_W       = 32;

    // major opcodes
    localparam logic [5:0] OPC_EQ        = 6'h04;
    localparam logic [5:0] OPC_EQ_LIKELY = 6'h14;
    localparam logic [5:0] OPC_REGISTER_IMMEDIATE_GROUP    = 6'h01;
    localparam logic [5:0] OPC_POS       = 6'h07;
    localparam logic [5:0] OPC_POS_LIKELY= 6'h17;
    localparam logic [5:0] OPC_NONPOS    = 6'h06;
    localparam logic [5:0] OPC_COP0      = 6'h10;

    // selectors under the register immediate group
    localparam logic [4:0] SEL_NONNEG    = 5'h01;
    localparam logic [4:0] SEL_NONNEG_L  = 5'h03;
    localparam logic [4:0] SEL_NONNEG_AL = 5'h11;
    localparam logic [4:0] SEL_NONNEG_ALL= 5'h13;

    // coprocessor branch sub-fields
    localparam logic [4:0] COP_BC        = 5'h08;
    localparam logic [4:0] COP_TRUE_L    = 5'h03;

    // link register index and address offsets
    localparam logic [4:0] LINK_REG      = 5'h1F;
    localparam logic [63:0] SLOT_OFFSET  = 64'h0000_0000_0000_0004;
    localparam logic [63:0] LINK_OFFSET  = 64'h0000_0000_0000_0008;

    // sequencing states, one-hot
    typedef enum logic [1:0] {
        CBU_IDLE    = 2'h1,
        CBU_RESOLVE = 2'h2
    } cbu_state_t;

endpackage

// ---- rtl/cbu_cond_eval.sv ----
// Purpose: operand tests for the branch unit (sign, zero, equality)
// Assumes: operands arrive from the register file on the same clock
// Notes:   in 32-bit mode only the low half is looked at
`timescale 1ns/10ps
`default_nettype none
module cbu_cond_eval #(
    parameter int unsigned WIDTH = cbu_pkg::DATA_W
) (
    input  wire logic [WIDTH-1:0] first_value,
    input  wire logic [WIDTH-1:0] second_value,
    input  wire logic             mode64,
    output logic                  sign_set,
    output logic                  is_zero,
    output logic                  equal
);

    // per-bit view of each operand, upper half masked in 32-bit mode
    logic [WIDTH-1:0] first_view;
    logic [WIDTH-1:0] second_view;

    // the upper half is ignored rather than checked for a proper
    // sign extension, so badly extended values still compare on 32 bits
    genvar b;
    generate
        for (b = 0; b < WIDTH; b++) begin : g_view
            if (b < cbu_pkg::HALF_W) begin : g_low
                assign first_view[b]  = first_value[b];
                assign second_view[b] = second_value[b];
            end else begin : g_high
                assign first_view[b]  = first_value[b] & mode64;
                assign second_view[b] = second_value[b] & mode64;
            end
        end
    endgenerate

    // sign bit: top bit in 64-bit mode, bit 31 in 32-bit mode
    assign sign_set = mode64 ? first_value[WIDTH-1]
                             : first_value[cbu_pkg::SIGN32_BIT];
    // zero over the active width
    assign is_zero  = (first_view == '0);
    // equality over the active width
    assign equal    = (first_view == second_view);

endmodule
`default_nettype wire

// ---- test/cbu_branch_unit_properties.sv ----
// Purpose: port-level checker for the conditional branch unit
// Assumes: one clock, synchronous active-low reset
// Notes:   most checks run in 64-bit mode; the bench covers 32-bit folding
`timescale 1ns/10ps
`default_nettype none
module cbu_branch_unit_properties #(
    parameter int unsigned DATA_W = 64
) (
    input wire logic              clk,
    input wire logic              nrst,
    input wire logic              issue_valid,
    input wire logic [31:0]       instr,
    input wire logic [DATA_W-1:0] branch_pc,
    input wire logic [DATA_W-1:0] first_source_value,
    input wire logic [DATA_W-1:0] second_source_value,
    input wire logic              mode64,
    input wire logic              cop0_usable,
    input wire logic [4:0]        first_source_field,
    input wire logic              redirect_valid,
    input wire logic [DATA_W-1:0] redirect_pc,
    input wire logic              nullify_slot,
    input wire logic              link_write,
    input wire logic [4:0]        link_index,
    input wire logic [DATA_W-1:0] link_value,
    input wire logic              cop_unusable_exc,
    input wire logic              link_self_hazard,
    input wire logic              resolve_busy
);
    // decoded views of the issued word
    logic [5:0]        opc;
    logic [4:0]        sel;
    logic              pos;
    logic              v64;
    logic [DATA_W-1:0] tgt;
    assign opc = instr[31:26];
    assign sel = instr[20:16];
    // strictly positive in the wide mode
    assign pos = !first_source_value[63] && (first_source_value != '0);
    assign v64 = issue_valid && mode64;
    // expected target, slot address plus scaled offset
    assign tgt = branch_pc + cbu_pkg::SLOT_OFFSET + {{46{instr[15]}}, instr[15:0], 2'b00};

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    AST_FIELD_SPLIT: assert property (
        first_source_field == instr[25:21]) else $error("source field slice wrong");
    AST_EQ_TAKEN: assert property (
        v64 && opc == cbu_pkg::OPC_EQ && first_source_value == second_source_value
        |=> redirect_valid && !nullify_slot && redirect_pc == $past(tgt)) else $error("equal branch not taken");
    AST_EQL_UNTAKEN: assert property (
        v64 && opc == cbu_pkg::OPC_EQ_LIKELY && first_source_value != second_source_value
        |=> nullify_slot && !redirect_valid) else $error("equal likely slot kept");
    AST_NONNEG_SIGN: assert property (
        v64 && opc == cbu_pkg::OPC_REGISTER_IMMEDIATE_GROUP && sel == cbu_pkg::SEL_NONNEG
        |=> redirect_valid == !$past(first_source_value[63])) else $error("nonnegative sign test wrong");
    AST_LINK_ALWAYS: assert property (
        v64 && opc == cbu_pkg::OPC_REGISTER_IMMEDIATE_GROUP && sel == cbu_pkg::SEL_NONNEG_AL
        |=> link_write && link_index == cbu_pkg::LINK_REG && link_value == $past(branch_pc) + 64'h8)
        else $error("link write missing");
    AST_LINK_NO_TRAP: assert property (
        issue_valid && opc == cbu_pkg::OPC_REGISTER_IMMEDIATE_GROUP && instr[25:21] == 5'h1F &&
        (sel == cbu_pkg::SEL_NONNEG_AL || sel == cbu_pkg::SEL_NONNEG_ALL)
        |=> link_self_hazard && !cop_unusable_exc) else $error("link on r31 mishandled");
    AST_LIKELY_NONNEG: assert property (
        v64 && opc == cbu_pkg::OPC_REGISTER_IMMEDIATE_GROUP && first_source_value[63] &&
        (sel == cbu_pkg::SEL_NONNEG_L || sel == cbu_pkg::SEL_NONNEG_ALL)
        |=> nullify_slot && !redirect_valid) else $error("likely nonnegative slot kept");
    AST_POS_STRICT: assert property (
        v64 && opc == cbu_pkg::OPC_POS |=> redirect_valid == $past(pos)) else $error("positive test wrong");
    AST_POSL_NULL: assert property (
        v64 && opc == cbu_pkg::OPC_POS_LIKELY && !pos |=> nullify_slot) else $error("positive likely slot kept");
    AST_NONPOS: assert property (
        v64 && opc == cbu_pkg::OPC_NONPOS |=> redirect_valid != $past(pos)) else $error("nonpositive test wrong");
    AST_COP_EXC: assert property (
        issue_valid && !cop0_usable && instr[31:16] == {cbu_pkg::OPC_COP0, cbu_pkg::COP_BC, cbu_pkg::COP_TRUE_L}
        |=> cop_unusable_exc && !redirect_valid && !nullify_slot) else $error("unusable exception missing");
    AST_IDLE_QUIET: assert property (
        !issue_valid |=> !redirect_valid && !nullify_slot && !link_write && !resolve_busy)
        else $error("outcome without issue");
endmodule
bind cbu_branch_unit cbu_branch_unit_properties #(.DATA_W(DATA_W)) u_props (.*);
`default_nettype wire

// ---- test/cbu_branch_unit_tb.sv ----
// Purpose: directed bench for the conditional branch unit
// Assumes: outcome shows one edge after the issuing edge
// Notes:   each run issues one word, then idles one cycle so pulses are seen alone
`timescale 1ns/10ps
`default_nettype none
module cbu_branch_unit_tb;
    logic        clk = 1'b0, nrst = 1'b0, issue_valid = 1'b0, mode64 = 1'b1;
    logic        cop0_usable = 1'b1, status_condition_bit = 1'b0;
    logic [31:0] instr = '0;
    logic [63:0] branch_pc = '0, first_source_value = '0, second_source_value = '0;
    logic [4:0]  first_source_field, second_source_field, link_index;
    logic        redirect_valid, nullify_slot, link_write, cop_unusable_exc, link_self_hazard, resolve_busy;
    logic [63:0] redirect_pc, link_value;
    int          error_cnt = 0;
    int          n_compared = 0;

    // 100 MHz clock
    always #5 clk = ~clk;

    cbu_branch_unit #(.DATA_W(64)) u_dut (
        .clk(clk), .nrst(nrst), .issue_valid(issue_valid), .instr(instr), .branch_pc(branch_pc),
        .first_source_value(first_source_value), .second_source_value(second_source_value),
        .mode64(mode64), .cop0_usable(cop0_usable), .status_condition_bit(status_condition_bit),
        .first_source_field(first_source_field), .second_source_field(second_source_field),
        .redirect_valid(redirect_valid), .redirect_pc(redirect_pc), .nullify_slot(nullify_slot),
        .link_write(link_write), .link_index(link_index), .link_value(link_value),
        .cop_unusable_exc(cop_unusable_exc), .link_self_hazard(link_self_hazard), .resolve_busy(resolve_busy));

    // verdict and end of run, shared with the watchdog
    task automatic summarize;
        $display("errors %0d compared %0d", error_cnt, n_compared);
        if (error_cnt == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
        n_compared++;
        if (got !== exp) begin
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
            error_cnt++;
        end
    endtask

    // narrow mode keeps addresses as sign-extended 32-bit values
    function automatic logic [63:0] fold(input logic [63:0] s);
        return mode64 ? s : {{32{s[31]}}, s[31:0]};
    endfunction

    function automatic logic [31:0] ins(input logic [5:0] o, input logic [4:0] s, t, input logic [15:0] f);
        return {o, s, t, f};
    endfunction

    // issue one word; e = {redirect, nullify, link, exception}
    task automatic run(input logic [31:0] w, input logic [63:0] pc, a, b, input logic cond, input logic [3:0] e);
        @(posedge clk);
        instr <= w;
        branch_pc <= pc;
        first_source_value <= a;
        second_source_value <= b;
        status_condition_bit <= cond;
        issue_valid <= 1'b1;
        @(posedge clk);
        issue_valid <= 1'b0;
        #1;
        chk("redirect_valid", e[3], redirect_valid);
        chk("nullify_slot", e[2], nullify_slot);
        chk("link_write", e[1], link_write);
        chk("cop_unusable_exc", e[0], cop_unusable_exc);
        chk("link_self_hazard", e[1] && w[25:21] == 5'h1F, link_self_hazard);
        chk("second_source_field", w[20:16], second_source_field);
        if (e[3]) chk("redirect_pc", fold(pc + 64'h4 + {{46{w[15]}}, w[15:0], 2'b00}), redirect_pc);
        if (e[1]) chk("link_value", fold(pc + 64'h8), link_value);
    endtask

    task automatic t_equal;
        run(ins(cbu_pkg::OPC_EQ, 5'h2, 5'h3, 16'h0010), 64'h1000, 64'h5, 64'h5, 1'b0, 4'b1000);
        chk("resolve_busy", 64'h1, resolve_busy);
        run(ins(cbu_pkg::OPC_EQ, 5'h2, 5'h3, 16'hFFF0), 64'h1000, 64'h1_0000_0005, 64'h5, 1'b0, 4'b0000);
        run(ins(cbu_pkg::OPC_EQ_LIKELY, 5'h4, 5'h5, 16'hFFFF), 64'h2000, 64'h7, 64'h7, 1'b0, 4'b1000);
        run(ins(cbu_pkg::OPC_EQ_LIKELY, 5'h4, 5'h5, 16'h0001), 64'h2000, 64'h7, 64'h8, 1'b0, 4'b0100);
    endtask

    // all four selectors, both sides of the sign boundary, source r31
    task automatic t_register_immediate_group;
        logic [4:0] sl [4];
        logic [4:0] s;
        sl = '{cbu_pkg::SEL_NONNEG, cbu_pkg::SEL_NONNEG_L, cbu_pkg::SEL_NONNEG_AL, cbu_pkg::SEL_NONNEG_ALL};
        for (int i = 0; i < 4; i++) begin
            s = sl[i];
            for (int n = 0; n < 2; n++) begin
                run(ins(cbu_pkg::OPC_REGISTER_IMMEDIATE_GROUP, 5'h1F, s, 16'h0020), 64'h3000, n ? 64'h8000_0000_0000_0000 :
                    64'h7FFF_FFFF_FFFF_FFFF, 64'h0, 1'b0, {n == 0, n == 1 && s[1], s[4], 1'b0});
            end
        end
    endtask

    // positive, zero and negative against the three zero tests
    task automatic t_zero;
        logic [5:0]  op [3];
        logic [63:0] vl [3];
        logic        p;
        op = '{cbu_pkg::OPC_POS, cbu_pkg::OPC_POS_LIKELY, cbu_pkg::OPC_NONPOS};
        vl = '{64'h1, 64'h0, 64'hFFFF_FFFF_FFFF_FFFF};
        for (int i = 0; i < 3; i++) begin
            for (int j = 0; j < 3; j++) begin
                p = (j == 0);
                run(ins(op[i], 5'h6, 5'h0, 16'h0008), 64'h4000, vl[j], 64'h0, 1'b0,
                    {(i == 2) ? !p : p, i == 1 && !p, 2'b00});
            end
        end
    endtask

    // narrow mode: bit 31 is the sign, upper halves ignored, sums folded
    task automatic t_mode32;
        @(posedge clk);
        mode64 <= 1'b0;
        run(ins(cbu_pkg::OPC_REGISTER_IMMEDIATE_GROUP, 5'h2, cbu_pkg::SEL_NONNEG, 16'h1), 64'h100, 64'h8000_0000, 64'h0, 1'b0, 4'b0000);
        run(ins(cbu_pkg::OPC_POS, 5'h2, 5'h0, 16'h1), 64'h7FFF_FFF8, 64'h8000_0000_0000_0001, 64'h0, 1'b0, 4'b1000);
        run(ins(cbu_pkg::OPC_EQ, 5'h2, 5'h3, 16'h2), 64'h200, 64'hAAAA_0000_0000_0009, 64'h9, 1'b0, 4'b1000);
        run(ins(cbu_pkg::OPC_REGISTER_IMMEDIATE_GROUP, 5'h4, cbu_pkg::SEL_NONNEG_AL, 16'h1), 64'h7FFF_FFF8, 64'h1, 64'h0, 1'b0, 4'b1010);
        @(posedge clk);
        mode64 <= 1'b1;
    endtask

    // condition is taken from the previous issued word, never the live one
    task automatic t_cop;
        logic [31:0] c;
        c = ins(cbu_pkg::OPC_COP0, cbu_pkg::COP_BC, cbu_pkg::COP_TRUE_L, 16'h0004);
        // spacing word between condition change and branch
        run(32'h0000_0000, 64'h100, 64'h0, 64'h0, 1'b1, 4'b0000);
        run(c, 64'h104, 64'h0, 64'h0, 1'b0, 4'b1000);
        run(c, 64'h108, 64'h0, 64'h0, 1'b1, 4'b0100);
        @(posedge clk);
        cop0_usable <= 1'b0;
        run(c, 64'h10C, 64'h0, 64'h0, 1'b1, 4'b0001);
        @(posedge clk);
        cop0_usable <= 1'b1;
    endtask

    // words outside the group give no outcome
    task automatic t_refused;
        run(ins(6'h23, 5'h1, 5'h2, 16'h4), 64'h500, 64'h0, 64'h0, 1'b0, 4'b0000);
        run(ins(cbu_pkg::OPC_REGISTER_IMMEDIATE_GROUP, 5'h1, 5'h05, 16'h4), 64'h500, 64'h0, 64'h0, 1'b0, 4'b0000);
        run(ins(cbu_pkg::OPC_COP0, 5'h09, cbu_pkg::COP_TRUE_L, 16'h4), 64'h500, 64'h0, 64'h0, 1'b1, 4'b0000);
    endtask

    // watchdog, far beyond the roughly ninety cycles the tests need
    initial begin
        #100000;
        error_cnt++;
        summarize();
    end

    initial begin
        repeat (20) @(posedge clk);
        #1;
        chk("redirect_pc reset", 64'h0, redirect_pc);
        chk("resolve_busy reset", 64'h0, resolve_busy);
        @(posedge clk);
        nrst <= 1'b1;
        t_equal();
        t_register_immediate_group();
        t_zero();
        t_mode32();
        t_cop();
        t_refused();
        summarize();
    end
endmodule
`default_nettype wire
